/* File: common/tmr_cfg.svh */
`ifndef TMR_CFG_SVH
`define TMR_CFG_SVH
// ----------------------------------------------------------------------------
// Timer register indices (device side, 8-bit registers).
// ----------------------------------------------------------------------------
`define TMR_IDX_CONTROL 4'h0
`define TMR_IDX_GATE 4'h1
`define TMR_IDX_COUNT_HIGH 4'h2
`define TMR_IDX_COUNT_LOW 4'h3
`define TMR_IDX_CLOCK_SEL 4'h4
`define TMR_IDX_ROLL_EN 4'h5
`define TMR_IDX_GATE_EN 4'h6
`define TMR_IDX_ROLL_FLAG 4'h7
`define TMR_IDX_GATE_FLAG 4'h8
`define TMR_IDX_MOD_DIS 4'h9
`define TMR_IDX_CCP_LOW 4'hA
`define TMR_IDX_CCP_HIGH 4'hB
`define TMR_IDX_CCP_MODE 4'hC
// ----------------------------------------------------------------------------
// Field positions.
// ----------------------------------------------------------------------------
`define TMR_CTL_ON 0
`define TMR_CTL_WIDE 1
`define TMR_CTL_SYNC_N 2
`define TMR_CTL_PS_LO 4
`define TMR_CTL_PS_HI 5
`define TMR_GCON_EN 7
`define TMR_GCON_POL 6
`define TMR_GCON_LVL 2
`define TMR_CCP_CMP 0
`define TMR_CCP_SPECIAL 1
`define TMR_CCP_CAP 2
// ----------------------------------------------------------------------------
// Reset values and limits.
// ----------------------------------------------------------------------------
`define TMR_RST_BYTE 8'h00
`define TMR_RST_COUNT 16'h0000
`define TMR_COUNT_MAX 16'hFFFF
// ----------------------------------------------------------------------------
// Controller APB map (byte addresses).
// ----------------------------------------------------------------------------
`define TMR_APB_CMD 8'h00
`define TMR_APB_RDATA 8'h04
`define TMR_APB_PINS 8'h08
`define TMR_APB_EVENTS 8'h0C
`define TMR_APB_STATUS 8'h10
`define TMR_CMD_WRITE 16
`define TMR_PIN_PEIE 4
`define TMR_PIN_GIE 5
`endif

/* File: common/tmr_pkg.sv */
`default_nettype none
package tmr_pkg;
  // Register index as carried over the link.
  typedef logic [3:0] tmr_addr_t;
  // Byte wide register data.
  typedef logic [7:0] tmr_byte_t;
  // Counter clock source select.
  typedef enum logic [1:0] {
    TMR_SRC_INSTR = 2'b00,
    TMR_SRC_PIN = 2'b01,
    TMR_SRC_SOSC = 2'b10
  } tmr_src_t;

  // Sticky flag update: a hardware set beats a software write of zero.
  function automatic logic tmr_flag_next(input logic hw_set, input logic sw_wr,
                                         input logic sw_bit, input logic q);
    tmr_flag_next = hw_set | (sw_wr ? sw_bit : q);
  endfunction : tmr_flag_next
endpackage : tmr_pkg
`default_nettype wire

/* File: common/tmr_link_if.sv */
`default_nettype none
interface tmr_link_if;
  // Register access from the controller.
  logic reg_wr;
  logic reg_rd;
  tmr_pkg::tmr_addr_t reg_addr;
  tmr_pkg::tmr_byte_t reg_wdata;
  tmr_pkg::tmr_byte_t reg_rdata;
  logic reg_rvalid;
  // Pin levels and events.
  logic gate_in;
  logic clk_pin;
  logic sosc_clk;
  logic sleep;
  logic capture_evt;
  logic special_trig;
  // Requests from the timer.
  logic rollover_irq;
  logic gate_irq;
  logic wake;

  modport dev(input reg_wr, reg_rd, reg_addr, reg_wdata, gate_in, clk_pin, sosc_clk, sleep,
              capture_evt, special_trig, output reg_rdata, reg_rvalid, rollover_irq, gate_irq, wake);
  modport ctl(output reg_wr, reg_rd, reg_addr, reg_wdata, gate_in, clk_pin, sosc_clk, sleep,
              capture_evt, special_trig, input reg_rdata, reg_rvalid, rollover_irq, gate_irq, wake);
endinterface : tmr_link_if
`default_nettype wire

/* File: design/tmr_timer_dev.sv */
`include "tmr_cfg.svh"
`default_nettype none
module tmr_timer_dev (
  // Clock and reset.
  input wire logic CLOCK,
  input wire logic RST_N,
  // Link to the controller.
  tmr_link_if.dev link,
  // User side.
  output logic [15:0] TIMER_COUNT,
  output logic COMPARE_EVENT
);
  import tmr_pkg::*;

  // --------------------------------------------------------------------------
  // Register decode.
  // --------------------------------------------------------------------------
  logic mdis_q; // Module disable bit.
  wire wr = link.reg_wr; // Write strobe.
  wire [3:0] ad = link.reg_addr; // Register index.
  wire [7:0] wd = link.reg_wdata; // Write data.
  wire wr_ctl = wr && ad == `TMR_IDX_CONTROL && !mdis_q;
  wire wr_gcon = wr && ad == `TMR_IDX_GATE && !mdis_q;
  wire wr_hi = wr && ad == `TMR_IDX_COUNT_HIGH && !mdis_q;
  wire wr_lo = wr && ad == `TMR_IDX_COUNT_LOW && !mdis_q;
  wire wr_csel = wr && ad == `TMR_IDX_CLOCK_SEL;
  wire wr_roen = wr && ad == `TMR_IDX_ROLL_EN;
  wire wr_geen = wr && ad == `TMR_IDX_GATE_EN;
  wire wr_rof = wr && ad == `TMR_IDX_ROLL_FLAG;
  wire wr_gef = wr && ad == `TMR_IDX_GATE_FLAG;
  wire wr_mdis = wr && ad == `TMR_IDX_MOD_DIS;
  wire wr_cl = wr && ad == `TMR_IDX_CCP_LOW;
  wire wr_ch = wr && ad == `TMR_IDX_CCP_HIGH;
  wire wr_cm = wr && ad == `TMR_IDX_CCP_MODE;
  wire rd_lo = link.reg_rd && ad == `TMR_IDX_COUNT_LOW;

  // --------------------------------------------------------------------------
  // State.
  // --------------------------------------------------------------------------
  logic [7:0] ctl_q; // Timer control byte.
  logic [7:0] gcon_q; // Gate control byte; the level bit is stored but reads return the registered gate level.
  tmr_src_t src_q; // Clock source select.
  logic roen_q, geen_q; // Interrupt enables.
  logic rof_q, gef_q; // Sticky event flags.
  logic [15:0] ccp_q; // Capture/compare pair.
  logic [2:0] ccpm_q; // Compare, special trigger, capture enables.
  logic [15:0] cnt_q, cnt_d; // Counter pair.
  logic [7:0] hbuf_q; // High byte buffer for wide access.
  logic [2:0] pre_q; // Prescaler.
  logic armed_q; // Falling edge seen since enable.
  logic src_prev_q; // Previous external clock level.
  logic gate_level_status_q; // Registered gate level.
  logic match_q; // Compare equality last cycle.
  logic [7:0] rdata_q;
  logic rvalid_q, roirq_q, geirq_q, wake_q, cmp_q;

  // --------------------------------------------------------------------------
  // Counting conditions.
  // --------------------------------------------------------------------------
  wire on = ctl_q[`TMR_CTL_ON] && !mdis_q;
  wire wide = ctl_q[`TMR_CTL_WIDE];
  wire [1:0] ps = ctl_q[`TMR_CTL_PS_HI:`TMR_CTL_PS_LO];
  wire [2:0] pre_mask = {ps == 2'h3, ps >= 2'h2, ps != 2'h0};
  // The oscillator level is seen whether or not sleep is on.
  wire src_lvl = (src_q == TMR_SRC_PIN) ? link.clk_pin : link.sosc_clk;
  wire ext_rise = src_lvl && !src_prev_q;
  wire ext_fall = !src_lvl && src_prev_q;
  wire is_instr = src_q == TMR_SRC_INSTR;
  wire raw_tick = is_instr ? 1'b1 : (ext_rise && armed_q);
  // In sleep only an unsynchronised external source keeps counting.
  wire run_ok = !link.sleep || (ctl_q[`TMR_CTL_SYNC_N] && !is_instr);
  // Gate level is always derived, enabled or not.
  wire gate_level_status = link.gate_in == gcon_q[`TMR_GCON_POL];
  wire gate_ok = !gcon_q[`TMR_GCON_EN] || gate_level_status;
  wire pre_tick = on && raw_tick && run_ok && gate_ok;
  wire inc = pre_tick && ((pre_q & pre_mask) == pre_mask);
  wire gate_fall = gate_level_status_q && !gate_level_status;
  wire match = ccpm_q[`TMR_CCP_CMP] && cnt_q == ccp_q;
  wire cmp_evt = match && !match_q;
  // A special trigger from any compare unit, including this one.
  wire spec_clr = link.special_trig || (cmp_evt && ccpm_q[`TMR_CCP_SPECIAL]);
  // Only a real wrap gives a hardware set of the flag; a write or a special clear at the top count
  // replaces the increment, so no rollover is reported.
  wire roll_hit = inc && cnt_q == `TMR_COUNT_MAX && !(wr_lo || wr_hi || spec_clr);
  wire rof_d = tmr_flag_next(roll_hit, wr_rof, wd[0], rof_q);
  wire gef_d = tmr_flag_next(gate_fall, wr_gef, wd[0], gef_q);

  // Next counter value; a byte write beats a special clear, which in turn
  // never touches the rollover flag.
  always_comb begin
    cnt_d = cnt_q;
    if (wr_lo) begin
      cnt_d = {wide ? hbuf_q : cnt_q[15:8], wd};
    end else if (wr_hi && !wide) begin
      cnt_d = {wd, cnt_q[7:0]};
    end else if (wr_hi) begin
      cnt_d = cnt_q; // The buffered write still blocks the clear.
    end else if (spec_clr) begin
      cnt_d = `TMR_RST_COUNT;
    end else if (inc) begin
      cnt_d = cnt_q + 16'h0001;
    end
  end

  // --------------------------------------------------------------------------
  // Counter, prescaler and edge tracking; all held clear while disabled.
  // --------------------------------------------------------------------------
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      cnt_q <= `TMR_RST_COUNT;
      pre_q <= 3'h0;
      armed_q <= 1'b0;
      src_prev_q <= 1'b0;
      hbuf_q <= `TMR_RST_BYTE;
    end else if (mdis_q) begin
      cnt_q <= `TMR_RST_COUNT;
      pre_q <= 3'h0;
      armed_q <= 1'b0;
      src_prev_q <= 1'b0;
      hbuf_q <= `TMR_RST_BYTE;
    end else begin
      cnt_q <= cnt_d;
      pre_q <= (wr_lo || !on) ? 3'h0 : (pre_tick ? pre_q + 3'h1 : pre_q);
      armed_q <= on && (armed_q || ext_fall);
      src_prev_q <= src_lvl;
      if (wr_hi && wide) begin
        hbuf_q <= wd;
      end else if (rd_lo && wide) begin
        hbuf_q <= cnt_q[15:8];
      end
    end
  end

  // Software registers; the timer's own control bytes are held in reset
  // while the module is disabled.
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      ctl_q <= `TMR_RST_BYTE;
      gcon_q <= `TMR_RST_BYTE;
      src_q <= TMR_SRC_INSTR;
      roen_q <= 1'b0;
      geen_q <= 1'b0;
      mdis_q <= 1'b0;
      ccpm_q <= 3'h0;
    end else begin
      ctl_q <= mdis_q ? `TMR_RST_BYTE : (wr_ctl ? wd : ctl_q);
      gcon_q <= mdis_q ? `TMR_RST_BYTE : (wr_gcon ? wd : gcon_q);
      if (wr_csel) begin
        src_q <= (wd[1:0] == 2'h3) ? TMR_SRC_INSTR : tmr_src_t'(wd[1:0]);
      end
      if (wr_roen) roen_q <= wd[0];
      if (wr_geen) geen_q <= wd[0];
      if (wr_mdis) mdis_q <= wd[0];
      if (wr_cm) ccpm_q <= wd[2:0];
    end
  end

  // Capture pair; a capture event beats a software write.
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      ccp_q <= `TMR_RST_COUNT;
    end else if (link.capture_evt && ccpm_q[`TMR_CCP_CAP]) begin
      ccp_q <= cnt_q;
    end else begin
      ccp_q <= {wr_ch ? wd : ccp_q[15:8], wr_cl ? wd : ccp_q[7:0]};
    end
  end

  // Flags, requests and the wake level.
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      rof_q <= 1'b0;
      gef_q <= 1'b0;
      gate_level_status_q <= 1'b0;
      match_q <= 1'b0;
      roirq_q <= 1'b0;
      geirq_q <= 1'b0;
      wake_q <= 1'b0;
      cmp_q <= 1'b0;
    end else begin
      rof_q <= rof_d;
      gef_q <= gef_d;
      gate_level_status_q <= gate_level_status;
      match_q <= match;
      roirq_q <= rof_d && roen_q;
      geirq_q <= gef_d && geen_q;
      wake_q <= link.sleep && rof_d && roen_q;
      cmp_q <= cmp_evt;
    end
  end

  // --------------------------------------------------------------------------
  // Read path: one cycle after the read strobe.
  // --------------------------------------------------------------------------
  logic [7:0] rmux;
  always_comb begin
    case (ad)
      `TMR_IDX_CONTROL: rmux = ctl_q;
      `TMR_IDX_GATE: rmux = {gcon_q[7:3], gate_level_status_q, gcon_q[1:0]};
      `TMR_IDX_COUNT_HIGH: rmux = wide ? hbuf_q : cnt_q[15:8];
      `TMR_IDX_COUNT_LOW: rmux = cnt_q[7:0];
      `TMR_IDX_CLOCK_SEL: rmux = {6'h00, src_q};
      `TMR_IDX_ROLL_EN: rmux = {7'h00, roen_q};
      `TMR_IDX_GATE_EN: rmux = {7'h00, geen_q};
      `TMR_IDX_ROLL_FLAG: rmux = {7'h00, rof_q};
      `TMR_IDX_GATE_FLAG: rmux = {7'h00, gef_q};
      `TMR_IDX_MOD_DIS: rmux = {7'h00, mdis_q};
      `TMR_IDX_CCP_LOW: rmux = ccp_q[7:0];
      `TMR_IDX_CCP_HIGH: rmux = ccp_q[15:8];
      `TMR_IDX_CCP_MODE: rmux = {5'h00, ccpm_q};
      default: rmux = `TMR_RST_BYTE;
    endcase
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      rdata_q <= `TMR_RST_BYTE;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= link.reg_rd;
      if (link.reg_rd) rdata_q <= rmux;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs.
  // --------------------------------------------------------------------------
  assign link.reg_rdata = rdata_q;
  assign link.reg_rvalid = rvalid_q;
  assign link.rollover_irq = roirq_q;
  assign link.gate_irq = geirq_q;
  assign link.wake = wake_q;
  assign TIMER_COUNT = cnt_q;
  assign COMPARE_EVENT = cmp_q;
endmodule : tmr_timer_dev
`default_nettype wire

/* File: design/tmr_host_ctl.sv */
`include "tmr_cfg.svh"
`default_nettype none
// Controller end: an APB slave that drives the timer link and combines the
// timer requests with the global enables, as the CPU side would.
module tmr_host_ctl (
  // Clock and reset.
  input wire logic CLOCK,
  input wire logic RST_N,
  // APB slave.
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Link to the timer.
  tmr_link_if.ctl link,
  // CPU side.
  output logic CPU_IRQ,
  output logic WAKE_UP
);
  import tmr_pkg::*;

  // --------------------------------------------------------------------------
  // Access decode; a write acts at the edge where PREADY is sampled high.
  // --------------------------------------------------------------------------
  logic pready_q, pslverr_q;
  logic [31:0] prdata_q;
  wire acc = PSEL && PENABLE;
  wire done = acc && pready_q;
  wire wr = done && PWRITE;
  wire mapped = PADDR == `TMR_APB_CMD || PADDR == `TMR_APB_RDATA || PADDR == `TMR_APB_PINS ||
                PADDR == `TMR_APB_EVENTS || PADDR == `TMR_APB_STATUS;
  wire wr_cmd = wr && PADDR == `TMR_APB_CMD;
  wire wr_pins = wr && PADDR == `TMR_APB_PINS;
  wire wr_evt = wr && PADDR == `TMR_APB_EVENTS;

  logic reg_wr_q, reg_rd_q, cap_q, spec_q;
  tmr_addr_t addr_q;
  tmr_byte_t wdata_q, rbuf_q;
  logic rbusy_q; // Read sent, data not yet back.
  logic [5:0] pins_q; // Gate, pin clock, oscillator, sleep, PEIE, GIE.
  logic irq_q, wake_q;

  // Link strobes are one-cycle pulses; orders are dropped while a read is pending.
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      reg_wr_q <= 1'b0;
      reg_rd_q <= 1'b0;
      addr_q <= 4'h0;
      wdata_q <= 8'h00;
      cap_q <= 1'b0;
      spec_q <= 1'b0;
      pins_q <= 6'h00;
    end else begin
      reg_wr_q <= wr_cmd && !rbusy_q && PWDATA[`TMR_CMD_WRITE];
      reg_rd_q <= wr_cmd && !rbusy_q && !PWDATA[`TMR_CMD_WRITE];
      if (wr_cmd && !rbusy_q) begin
        addr_q <= PWDATA[11:8];
        wdata_q <= PWDATA[7:0];
      end
      cap_q <= wr_evt && PWDATA[0];
      spec_q <= wr_evt && PWDATA[1];
      if (wr_pins) pins_q <= PWDATA[5:0];
    end
  end

  // Read result capture.
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      rbusy_q <= 1'b0;
      rbuf_q <= 8'h00;
    end else begin
      if (link.reg_rvalid) begin
        rbuf_q <= link.reg_rdata;
      end
      rbusy_q <= (rbusy_q && !link.reg_rvalid) || (wr_cmd && !rbusy_q && !PWDATA[`TMR_CMD_WRITE]);
    end
  end

  // Interrupt vectoring needs both enables; wake is passed through.
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      irq_q <= 1'b0;
      wake_q <= 1'b0;
    end else begin
      irq_q <= (link.rollover_irq || link.gate_irq) && pins_q[`TMR_PIN_PEIE] && pins_q[`TMR_PIN_GIE];
      wake_q <= link.wake;
    end
  end

  // --------------------------------------------------------------------------
  // APB answer: PREADY rises one cycle into the access phase.
  // --------------------------------------------------------------------------
  logic [31:0] rd_mux;
  always_comb begin
    case (PADDR)
      `TMR_APB_CMD: rd_mux = {15'h0000, 1'b0, 4'h0, addr_q, wdata_q};
      `TMR_APB_RDATA: rd_mux = {23'h000000, rbusy_q, rbuf_q};
      `TMR_APB_PINS: rd_mux = {26'h0000000, pins_q};
      `TMR_APB_STATUS: rd_mux = {27'h0000000, wake_q, irq_q, link.wake, link.gate_irq, link.rollover_irq};
      default: rd_mux = 32'h00000000;
    endcase
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h00000000;
    end else begin
      pready_q <= acc && !pready_q;
      pslverr_q <= acc && !pready_q && !mapped;
      prdata_q <= (acc && !pready_q && !PWRITE) ? rd_mux : 32'h00000000;
    end
  end

  assign PREADY = pready_q;
  assign PSLVERR = pslverr_q;
  assign PRDATA = prdata_q;
  assign CPU_IRQ = irq_q;
  assign WAKE_UP = wake_q;
  assign link.reg_wr = reg_wr_q;
  assign link.reg_rd = reg_rd_q;
  assign link.reg_addr = addr_q;
  assign link.reg_wdata = wdata_q;
  assign link.gate_in = pins_q[0];
  assign link.clk_pin = pins_q[1];
  assign link.sosc_clk = pins_q[2];
  assign link.sleep = pins_q[3];
  assign link.capture_evt = cap_q;
  assign link.special_trig = spec_q;
endmodule : tmr_host_ctl
`default_nettype wire

/* File: verification/tmr_link_chk.sv */
`default_nettype none
module tmr_link_chk (
  // Clock and reset.
  input wire logic CLOCK,
  input wire logic RST_N,
  // Register access on the link.
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire tmr_pkg::tmr_addr_t reg_addr,
  input wire tmr_pkg::tmr_byte_t reg_wdata,
  input wire tmr_pkg::tmr_byte_t reg_rdata,
  input wire logic reg_rvalid,
  // Levels and requests.
  input wire logic gate_in,
  input wire logic sleep,
  input wire logic rollover_irq,
  input wire logic gate_irq,
  input wire logic wake
);
  timeunit 1ns;
  timeprecision 1ps;
  import tmr_pkg::*;
  // -------------------------------------------------------------------------
  // Shadow of the device settings, rebuilt from the link writes.
  // -------------------------------------------------------------------------
  logic ren_q;  // Rollover enable.
  logic gen_q;  // Gate event enable.
  logic gate_polarity_q; // Gate polarity, cleared while disabled.
  logic dis_q;  // Module disable.
  logic lvl_q;  // Gate level as the device registers it.
  // The shadow follows the same write edge as the device, so no lag arises.
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      ren_q <= 1'b0;
      gen_q <= 1'b0;
      gate_polarity_q <= 1'b0;
      dis_q <= 1'b0;
      lvl_q <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == 4'h5) ren_q <= reg_wdata[0];
      if (reg_wr && reg_addr == 4'h6) gen_q <= reg_wdata[0];
      if (reg_wr && reg_addr == 4'h9) dis_q <= reg_wdata[0];
      if (dis_q) gate_polarity_q <= 1'b0;
      else if (reg_wr && reg_addr == 4'h1) gate_polarity_q <= reg_wdata[6];
      lvl_q <= (gate_in == gate_polarity_q);
    end
  end
  // -------------------------------------------------------------------------
  // Properties.
  // -------------------------------------------------------------------------
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_N);
  chk_gate_fall_flag: assert property ($fell(lvl_q) && gen_q && !dis_q |-> ##[0:3] gate_irq)
    else $error("gate fall did not raise the gate request");
  chk_gate_irq_enable: assert property (gate_irq |-> gen_q || $past(gen_q))
    else $error("gate request without its enable");
  chk_roll_irq_enable: assert property (rollover_irq |-> ren_q || $past(ren_q))
    else $error("rollover request without its enable");
  chk_roll_sticky: assert property (rollover_irq && !(reg_wr && reg_addr inside {4'h5, 4'h7}) |=> rollover_irq)
    else $error("rollover request dropped by itself");
  chk_flag_write_set: assert property (reg_wr && reg_addr == 4'h7 && reg_wdata[0] && ren_q |-> ##[1:2] rollover_irq)
    else $error("flag write of one not seen");
  chk_wake_in_sleep: assert property (wake |-> sleep || $past(sleep))
    else $error("wake outside sleep");
  chk_wake_on_roll: assert property (sleep && rollover_irq && $past(sleep && rollover_irq) |-> ##[0:1] wake)
    else $error("no wake on rollover in sleep");
  chk_disabled_count: assert property (reg_rd && reg_addr == 4'h3 && dis_q && $past(dis_q)
    |=> reg_rvalid && reg_rdata == 8'h00)
    else $error("count not held in reset while disabled");
  chk_read_answer: assert property (reg_rd |=> reg_rvalid)
    else $error("read not answered next cycle");
  // Main scenarios reached.
  cover property ($rose(gate_irq));
  cover property ($rose(wake));
  cover property (reg_rd && reg_addr == 4'h3 && dis_q);
endmodule : tmr_link_chk
`default_nettype wire

/* File: verification/timer16_irq_trigger_logic_tb.sv */
`default_nettype none
module timer16_irq_trigger_logic_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import tmr_pkg::*;
  logic CLOCK, RST_N, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, CPU_IRQ, WAKE_UP, COMPARE_EVENT, er;
  logic [7:0] PADDR;
  logic [31:0] PWDATA, PRDATA, rd;
  logic [15:0] TIMER_COUNT;
  int mismatches, compares, cycles, n;
  // -------------------------------------------------------------------------
  // The two ends face each other across the link.
  // -------------------------------------------------------------------------
  tmr_link_if lnk ();
  tmr_timer_dev tmr_timer_dev_i (.CLOCK(CLOCK), .RST_N(RST_N), .link(lnk.dev),
    .TIMER_COUNT(TIMER_COUNT), .COMPARE_EVENT(COMPARE_EVENT));
  tmr_host_ctl tmr_host_ctl_i (.CLOCK(CLOCK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .link(lnk.ctl), .CPU_IRQ(CPU_IRQ), .WAKE_UP(WAKE_UP));
  tmr_link_chk tmr_link_chk_i (.CLOCK(CLOCK), .RST_N(RST_N), .reg_wr(lnk.reg_wr), .reg_rd(lnk.reg_rd),
    .reg_addr(lnk.reg_addr), .reg_wdata(lnk.reg_wdata), .reg_rdata(lnk.reg_rdata),
    .reg_rvalid(lnk.reg_rvalid), .gate_in(lnk.gate_in), .sleep(lnk.sleep),
    .rollover_irq(lnk.rollover_irq), .gate_irq(lnk.gate_irq), .wake(lnk.wake));
  // -------------------------------------------------------------------------
  // Clock and hang guard.
  // -------------------------------------------------------------------------
  initial begin
    CLOCK = 1'b0;
    forever #4 CLOCK = ~CLOCK;
  end
  // The whole run needs well under a thousand cycles, so this ceiling means a hang.
  always @(posedge CLOCK) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      complete_run();
    end
  end
  task complete_run();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : complete_run
  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // -------------------------------------------------------------------------
  // Bus tasks.
  // -------------------------------------------------------------------------
  // One APB transfer; an idle cycle before setup keeps each signal to one write per step.
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    n = 0;
    @(posedge CLOCK);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLOCK);
    PENABLE <= 1'b1;
    // The request stands until the edge that samples PREADY high; data is taken there.
    do begin
      @(posedge CLOCK);
      n++;
    end while (PREADY !== 1'b1 && n < 40);
    if (PREADY !== 1'b1) mismatches++;
    rd = PRDATA;
    er = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask : apb
  // A new command is dropped while busy, so every command waits it out.
  task busy();
    do apb(1'b0, 8'h04, 32'h0000_0000);
    while (rd[8] === 1'b1);
  endtask : busy
  task dwr(input tmr_addr_t i, input tmr_byte_t v);
    apb(1'b1, 8'h00, {15'h0000, 1'b1, 4'h0, i, v});
    busy();
  endtask : dwr
  task rchk(input tmr_addr_t i, input tmr_byte_t e);
    apb(1'b1, 8'h00, {20'h00000, i, 8'h00});
    busy();
    chk($sformatf("register %0h", i), {24'h000000, rd[7:0]}, {24'h000000, e});
  endtask : rchk
  task pins(input logic [7:0] v);
    apb(1'b1, 8'h08, {24'h000000, v});
  endtask : pins
  task st(input logic [31:0] e);
    apb(1'b0, 8'h10, 32'h0000_0000);
    chk("status", rd, e);
  endtask : st
  // -------------------------------------------------------------------------
  // Main sequence.
  // -------------------------------------------------------------------------
  initial begin
    RST_N = 1'b0;
    PSEL = 1'b0;
    PENABLE = 1'b0;
    PWRITE = 1'b0;
    PADDR = 8'h00;
    PWDATA = 32'h0000_0000;
    repeat (12) @(posedge CLOCK);
    RST_N <= 1'b1;
    // Every device register clears; gate level reads high with gate low and polarity low.
    for (int i = 0; i < 13; i++) if (i != 1) rchk(4'(i), 8'h00);
    rchk(4'h1, 8'h04);
    apb(1'b0, 8'h14, 32'h0000_0000);
    chk("unmapped error", {31'h0, er}, 32'h0000_0001);
    chk("unmapped data", rd, 32'h0000_0000);
    // Rollover without enable, then with the enable chain.
    dwr(4'h2, 8'hFF);
    dwr(4'h3, 8'hFE);
    dwr(4'h0, 8'h01);
    rchk(4'h7, 8'h01);
    st(32'h0000_0000);
    dwr(4'h5, 8'h01);
    st(32'h0000_0001);
    pins(8'h30);
    st(32'h0000_0009);
    dwr(4'h7, 8'h00);
    st(32'h0000_0000);
    dwr(4'h7, 8'h01);
    st(32'h0000_0009);
    dwr(4'h7, 8'h00);
    pins(8'h00);
    dwr(4'h0, 8'h00);
    // Gate events with the gate function off; polarity high makes level follow the pin.
    dwr(4'h1, 8'h40);
    dwr(4'h8, 8'h00);
    dwr(4'h6, 8'h01);
    pins(8'h01);
    rchk(4'h1, 8'h44);
    rchk(4'h8, 8'h00);
    pins(8'h00);
    rchk(4'h8, 8'h01);
    st(32'h0000_0002);
    dwr(4'h8, 8'h00);
    rchk(4'h8, 8'h00);
    dwr(4'h6, 8'h00);
    // Compare with special trigger at the top count: the clear meets the wrap and must win.
    dwr(4'h2, 8'hFF);
    dwr(4'h3, 8'hF0);
    dwr(4'hA, 8'hFF);
    dwr(4'hB, 8'hFF);
    dwr(4'hC, 8'h03);
    dwr(4'h0, 8'h01);
    n = 0;
    while (COMPARE_EVENT !== 1'b1 && n < 300) begin
      @(negedge CLOCK);
      n++;
    end
    chk("compare seen", {31'h0, COMPARE_EVENT}, 32'h0000_0001);
    chk("cleared count", {31'h0, TIMER_COUNT < 16'h0003}, 32'h0000_0001);
    repeat (3) rchk(4'h7, 8'h00);
    dwr(4'h0, 8'h00);
    // Capture copies the stopped count.
    dwr(4'h2, 8'h12);
    dwr(4'h3, 8'h34);
    dwr(4'hC, 8'h04);
    apb(1'b1, 8'h0C, 32'h0000_0001);
    rchk(4'hA, 8'h34);
    rchk(4'hB, 8'h12);
    apb(1'b1, 8'h0C, 32'h0000_0002);
    // The trigger pulse reaches the counter one edge after the bus write.
    repeat (2) @(negedge CLOCK);
    chk("special clear", {16'h0000, TIMER_COUNT}, 32'h0000_0000);
    rchk(4'h7, 8'h00);
    dwr(4'hC, 8'h00);
    // Disabled module holds the count in reset and refuses count writes.
    dwr(4'h3, 8'h55);
    dwr(4'h9, 8'h01);
    rchk(4'h3, 8'h00);
    dwr(4'h3, 8'h77);
    rchk(4'h3, 8'h00);
    dwr(4'h9, 8'h00);
    // Sleep: frozen on the instruction clock, counting from the oscillator.
    dwr(4'h2, 8'hFF);
    dwr(4'h3, 8'hFF);
    pins(8'h18);
    dwr(4'h0, 8'h01);
    chk("sleep frozen", {16'h0000, TIMER_COUNT}, 32'h0000_FFFF);
    dwr(4'h0, 8'h00);
    dwr(4'h4, 8'h02);
    dwr(4'h0, 8'h05);
    pins(8'h1C);
    repeat (2) @(negedge CLOCK);
    chk("first rise", {16'h0000, TIMER_COUNT}, 32'h0000_FFFF);
    pins(8'h18);
    pins(8'h1C);
    repeat (2) @(negedge CLOCK);
    chk("sleep wrap", {16'h0000, TIMER_COUNT}, 32'h0000_0000);
    st(32'h0000_0015);
    pins(8'h3C);
    st(32'h0000_001D);
    complete_run();
  end
endmodule : timer16_irq_trigger_logic_tb
`default_nettype wire
